// [hdl/dma_ctrl.sv]
// eight-channel dma engine: peripheral bus master plus sram port
// assumes sram and peripherals drive read data while the read pulse stands,
// and that CPU_PERIPH_REQ rises one cycle before the cpu uses the bus
//
// Behaviour
// - The engine masters the dma peripheral bus and moves data to and from its peripherals.
// - Whenever the cpu asks for the peripheral bus the engine leaves it to the cpu.
// - Transfers run beside the cpu and never make the cpu wait.
// - A private sram port moves data to and from memory without the cpu.
// - Eight channels are each configured and run on their own.
// - Each channel has 16-bit source and destination pointers that advance and reload.
// - Each channel has a 16-bit transaction counter that counts down and reloads.
// - Sram addresses outside the lower and upper limits abort the channel.
// - A pulse marks the moment a channel's counter reaches half of its start value.
// - Each channel moves either bytes or 16-bit words.
// - Five address modes, four transfer modes and four data paths are selectable.
// - Null-write mode follows each peripheral read with a dummy zero write to it.
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl
	import dma_pkg::*;
(
	input  wire logic                                    SYS_CLK,
	input  wire logic                                    RST_N,
	input  wire logic [dma_pkg::NUM_CH-1:0]              CH_ENABLE,
	input  wire logic [dma_pkg::NUM_CH-1:0]              CH_TRIGGER,
	input  wire logic [dma_pkg::NUM_CH-1:0][15:0]        SRC_START,
	input  wire logic [dma_pkg::NUM_CH-1:0][15:0]        DST_START,
	input  wire logic [dma_pkg::NUM_CH-1:0][15:0]        COUNT_START,
	input  wire logic [dma_pkg::NUM_CH-1:0][2:0]         ADDR_MODE,
	input  wire logic [dma_pkg::NUM_CH-1:0][1:0]         XFER_MODE,
	input  wire logic [dma_pkg::NUM_CH-1:0][1:0]         DATA_MODE,
	input  wire logic [dma_pkg::NUM_CH-1:0]              BYTE_MODE,
	input  wire logic [dma_pkg::NUM_CH-1:0]              NULL_WRITE,
	input  wire logic [dma_pkg::ADDR_W-1:0]              LOWER_LIMIT,
	input  wire logic [dma_pkg::ADDR_W-1:0]              UPPER_LIMIT,
	input  wire logic                                    CPU_PERIPH_REQ,
	output logic                                         CPU_OWNS_PBUS,
	output logic [dma_pkg::ADDR_W-1:0]                   PBUS_ADDR,
	output logic [dma_pkg::DATA_W-1:0]                   PBUS_WDATA,
	input  wire logic [dma_pkg::DATA_W-1:0]              PBUS_RDATA,
	output logic                                         PBUS_RD,
	output logic                                         PBUS_WR,
	output logic                                         PBUS_BYTE,
	output logic [dma_pkg::ADDR_W-1:0]                   RAM_ADDR,
	output logic [dma_pkg::DATA_W-1:0]                   RAM_WDATA,
	input  wire logic [dma_pkg::DATA_W-1:0]              RAM_RDATA,
	output logic                                         RAM_RD,
	output logic                                         RAM_WR,
	output logic                                         RAM_BYTE,
	output logic [dma_pkg::NUM_CH-1:0]                   CH_ACTIVE,
	output logic [dma_pkg::NUM_CH-1:0]                   CH_DONE,
	output logic [dma_pkg::NUM_CH-1:0]                   CH_HALF,
	output logic [dma_pkg::NUM_CH-1:0]                   CH_LIMIT_ERR
);
	import dma_pkg::*;

	typedef enum logic [1:0] {R_IDLE, R_READ, R_CAPT, R_NULL} rd_state_t;

	typedef struct packed {
		rd_state_t                       rstate;
		logic [CH_W-1:0]                 cur;
		logic [NUM_CH-1:0]               en_q;
		logic [NUM_CH-1:0]               active;
		logic [NUM_CH-1:0]               pend;
		logic [NUM_CH-1:0]               limit_err;
		logic [NUM_CH-1:0]               done;
		logic [NUM_CH-1:0]               half;
		logic [NUM_CH-1:0][ADDR_W-1:0]   src_ptr;
		logic [NUM_CH-1:0][ADDR_W-1:0]   dst_ptr;
		logic [NUM_CH-1:0][CNT_W-1:0]    cnt;
		logic [ADDR_W-1:0]               rd_addr;
		logic                            rd_src_ram;
		logic                            cpu_owns;
		logic [ADDR_W-1:0]               pbus_addr;
		logic [DATA_W-1:0]               pbus_wdata;
		logic                            pbus_rd;
		logic                            pbus_wr;
		logic                            pbus_byte;
		logic [ADDR_W-1:0]               ram_addr;
		logic [DATA_W-1:0]               ram_wdata;
		logic                            ram_rd;
		logic                            ram_wr;
		logic                            ram_byte;
	} dma_st_t;

	dma_st_t    s_reg;
	dma_st_t    s_next;
	fifo_word_t fin;
	fifo_word_t fout;
	logic [FW_W-1:0] fout_bits;
	logic       fin_valid;
	logic       fin_ready;
	logic       fout_valid;
	logic       wr_go;

	// pointer step for one side of a channel
	function automatic logic [ADDR_W-1:0] next_addr(
		input logic [ADDR_W-1:0] a,
		input logic [2:0]        mode,
		input logic              is_src,
		input logic              byte_sz);
		logic [ADDR_W-1:0] st;
		st = byte_sz ? STEP_BYTE : STEP_WORD;
		unique case (mode)
			AM_INC_SRC:  next_addr = is_src ? a + st : a;
			AM_INC_DST:  next_addr = is_src ? a : a + st;
			AM_INC_BOTH: next_addr = a + st;
			AM_DEC_BOTH: next_addr = a - st;
			default:     next_addr = a;
		endcase
	endfunction

	// inclusive window check on sram addresses
	function automatic logic in_limits(input logic [ADDR_W-1:0] a);
		in_limits = (a >= LOWER_LIMIT) && (a <= UPPER_LIMIT);
	endfunction

	// fixed priority: lowest numbered requesting channel wins
	function automatic logic [CH_W-1:0] pick(input logic [NUM_CH-1:0] r);
		pick = '0;
		for (int k = NUM_CH-1; k >= 0; k--) begin
			if (r[k]) begin
				pick = CH_W'(k);
			end
		end
	endfunction

	// element entering the fifo in the capture cycle
	always_comb begin
		fin.data    = s_reg.rd_src_ram ? RAM_RDATA : PBUS_RDATA;
		if (BYTE_MODE[s_reg.cur]) begin
			fin.data = {8'h00, fin.data[7:0]};
		end
		fin.dst     = s_reg.dst_ptr[s_reg.cur];
		fin.ch      = s_reg.cur;
		fin.dst_ram = DATA_MODE[s_reg.cur][DM_DST_RAM_BIT];
		fin.byte_sz = BYTE_MODE[s_reg.cur];
		fin.last    = (s_reg.cnt[s_reg.cur] == CNT_W'(1));
		fin.half    = (COUNT_START[s_reg.cur] >= CNT_W'(2)) &&
			(s_reg.cnt[s_reg.cur] - CNT_W'(1) ==
			 (COUNT_START[s_reg.cur] >> 1));
	end

	assign fin_valid = (s_reg.rstate == R_CAPT);
	assign fout      = fifo_word_t'(fout_bits);
	// a write to the peripheral bus waits while the cpu holds it
	assign wr_go = fout_valid && !(!fout.dst_ram && CPU_PERIPH_REQ);

	dma_fifo #(
		.WIDTH (FW_W),
		.DEPTH (FIFO_DP)
	) u_fifo (
		.SYS_CLK   (SYS_CLK),
		.RST_N     (RST_N),
		.in_valid  (fin_valid),
		.in_ready  (fin_ready),
		.in_data   (fin),
		.out_valid (fout_valid),
		.out_ready (wr_go),
		.out_data  (fout_bits)
	);

	// write engine, read engine, then per-channel enables and triggers
	always_comb begin
		logic              ram_busy;
		logic              pbus_busy;
		logic              src_ram;
		logic              dst_ram;
		logic [CH_W-1:0]   c;
		logic [NUM_CH-1:0] req;
		ram_busy  = 1'b0;
		pbus_busy = CPU_PERIPH_REQ;
		src_ram   = 1'b0;
		dst_ram   = 1'b0;
		c         = s_reg.cur;
		req       = s_reg.active & s_reg.pend;
		s_next          = s_reg;
		s_next.pbus_rd  = 1'b0;
		s_next.pbus_wr  = 1'b0;
		s_next.ram_rd   = 1'b0;
		s_next.ram_wr   = 1'b0;
		s_next.done     = '0;
		s_next.half     = '0;
		s_next.cpu_owns = CPU_PERIPH_REQ;
		// drain one element from the fifo to its destination
		if (wr_go) begin
			if (fout.dst_ram) begin
				ram_busy           = 1'b1;
				s_next.ram_wr      = 1'b1;
				s_next.ram_addr    = fout.dst;
				s_next.ram_wdata   = fout.data;
				s_next.ram_byte    = fout.byte_sz;
			end else begin
				pbus_busy          = 1'b1;
				s_next.pbus_wr     = 1'b1;
				s_next.pbus_addr   = fout.dst;
				s_next.pbus_wdata  = fout.data;
				s_next.pbus_byte   = fout.byte_sz;
			end
			s_next.done[fout.ch] = fout.last;
			s_next.half[fout.ch] = fout.half;
		end
		src_ram = DATA_MODE[c][DM_SRC_RAM_BIT];
		dst_ram = DATA_MODE[c][DM_DST_RAM_BIT];
		unique case (s_reg.rstate)
			R_IDLE: begin
				if (req != '0) begin
					s_next.cur    = pick(req);
					s_next.rstate = R_READ;
				end
			end
			R_READ: begin
				if (!s_reg.active[c]) begin
					s_next.rstate = R_IDLE;
				end else if ((src_ram && !in_limits(s_reg.src_ptr[c])) ||
					(dst_ram && !in_limits(s_reg.dst_ptr[c]))) begin
					s_next.limit_err[c] = 1'b1;
					s_next.active[c]    = 1'b0;
					s_next.pend[c]      = 1'b0;
					s_next.rstate       = R_IDLE;
				end else if (fin_ready && (src_ram ? !ram_busy : !pbus_busy)) begin
					s_next.rd_addr    = s_reg.src_ptr[c];
					s_next.rd_src_ram = src_ram;
					if (src_ram) begin
						s_next.ram_rd   = 1'b1;
						s_next.ram_addr = s_reg.src_ptr[c];
						s_next.ram_byte = BYTE_MODE[c];
					end else begin
						s_next.pbus_rd   = 1'b1;
						s_next.pbus_addr = s_reg.src_ptr[c];
						s_next.pbus_byte = BYTE_MODE[c];
					end
					s_next.rstate = R_CAPT;
				end
			end
			R_CAPT: begin
				s_next.src_ptr[c] = next_addr(s_reg.src_ptr[c],
					ADDR_MODE[c], 1'b1, BYTE_MODE[c]);
				s_next.dst_ptr[c] = next_addr(s_reg.dst_ptr[c],
					ADDR_MODE[c], 1'b0, BYTE_MODE[c]);
				s_next.cnt[c] = s_reg.cnt[c] - CNT_W'(1);
				if (XFER_MODE[c][XM_ELEMENT_BIT]) begin
					s_next.pend[c] = 1'b0;
				end
				if (fin.last) begin
					s_next.pend[c] = 1'b0;
					if (XFER_MODE[c][XM_REPEAT_BIT]) begin
						s_next.src_ptr[c] = SRC_START[c];
						s_next.dst_ptr[c] = DST_START[c];
						s_next.cnt[c]     = COUNT_START[c];
					end else begin
						s_next.active[c] = 1'b0;
					end
				end
				s_next.rstate = (NULL_WRITE[c] && !s_reg.rd_src_ram) ?
					R_NULL : R_IDLE;
			end
			R_NULL: begin
				if (!pbus_busy) begin
					s_next.pbus_wr    = 1'b1;
					s_next.pbus_addr  = s_reg.rd_addr;
					s_next.pbus_wdata = NULL_DATA;
					s_next.pbus_byte  = BYTE_MODE[c];
					s_next.rstate     = R_IDLE;
				end
			end
		endcase
		// independent enable, load and trigger per channel
		for (int i = 0; i < NUM_CH; i++) begin
			s_next.en_q[i] = CH_ENABLE[i];
			if (!CH_ENABLE[i]) begin
				s_next.active[i] = 1'b0;
				s_next.pend[i]   = 1'b0;
			end else if (!s_reg.en_q[i]) begin
				s_next.src_ptr[i]   = SRC_START[i];
				s_next.dst_ptr[i]   = DST_START[i];
				s_next.cnt[i]       = COUNT_START[i];
				s_next.active[i]    = (COUNT_START[i] != CNT_RST);
				s_next.limit_err[i] = 1'b0;
			end
			// a trigger arriving with the clear still counts
			if (CH_ENABLE[i] && CH_TRIGGER[i]) begin
				s_next.pend[i] = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_reg        <= '0;
			s_reg.rstate <= R_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// all outputs come from the state register
	assign CPU_OWNS_PBUS = s_reg.cpu_owns;
	assign PBUS_ADDR     = s_reg.pbus_addr;
	assign PBUS_WDATA    = s_reg.pbus_wdata;
	assign PBUS_RD       = s_reg.pbus_rd;
	assign PBUS_WR       = s_reg.pbus_wr;
	assign PBUS_BYTE     = s_reg.pbus_byte;
	assign RAM_ADDR      = s_reg.ram_addr;
	assign RAM_WDATA     = s_reg.ram_wdata;
	assign RAM_RD        = s_reg.ram_rd;
	assign RAM_WR        = s_reg.ram_wr;
	assign RAM_BYTE      = s_reg.ram_byte;
	assign CH_ACTIVE     = s_reg.active;
	assign CH_DONE       = s_reg.done;
	assign CH_HALF       = s_reg.half;
	assign CH_LIMIT_ERR  = s_reg.limit_err;

	// checks on the engine
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_read_issued;
		PBUS_RD || RAM_RD;
	endsequence

	sequence s_null_pending;
		s_reg.rstate == R_NULL;
	endsequence

	a_cpu_bus_yield: assert property (
		CPU_PERIPH_REQ |=> !PBUS_RD && !PBUS_WR)
		else $error("peripheral bus driven while the cpu asked for it");

	a_no_cpu_stall: assert property (
		CPU_OWNS_PBUS |-> !PBUS_RD && !PBUS_WR)
		else $error("dma access overlaps a cpu peripheral cycle");

	a_read_to_fifo: assert property (
		s_read_issued |-> s_reg.rstate == R_CAPT ##1 s_reg.rstate != R_CAPT)
		else $error("read data not captured in the following cycle");

	a_single_read: assert property (
		!(PBUS_RD && RAM_RD))
		else $error("two channels read at once");

	a_ram_limits: assert property (
		RAM_RD |-> $past(in_limits(s_reg.ram_addr)) || in_limits(RAM_ADDR))
		else $error("sram read outside the address window");

	a_byte_lane: assert property (
		RAM_WR && RAM_BYTE |-> RAM_WDATA[15:8] == 8'h00)
		else $error("byte write carries data in the upper lane");

	a_count_step: assert property (
		s_reg.rstate == R_CAPT && !fin.last && CH_ENABLE[s_reg.cur] &&
		s_reg.en_q[s_reg.cur]
		|=> s_reg.cnt[$past(s_reg.cur)] == $past(s_reg.cnt[s_reg.cur]) - 16'h0001)
		else $error("transaction counter did not step by one");

	a_oneshot_stop: assert property (
		s_reg.rstate == R_CAPT && fin.last &&
		!XFER_MODE[s_reg.cur][XM_REPEAT_BIT]
		|=> !s_reg.active[$past(s_reg.cur)])
		else $error("exhausted one-shot channel stayed active");

	a_half_pulse: assert property (
		wr_go && fout.half |=> CH_HALF != '0 ##1 CH_HALF == '0 || wr_go)
		else $error("half level pulse missing");

	a_null_write: assert property (
		s_null_pending ##0 !CPU_PERIPH_REQ ##0 !(wr_go && !fout.dst_ram)
		|=> PBUS_WR && PBUS_WDATA == 16'h0000)
		else $error("null write not issued");
endmodule
`default_nettype wire

// [hdl/dma_pkg.sv]
// shared constants and types of the eight-channel dma controller
// assumes one clock domain and configuration held steady by the core
package dma_pkg;

	// channel count and datapath widths
	localparam int NUM_CH  = 8;
	localparam int CH_W    = 3;
	localparam int ADDR_W  = 16;
	localparam int DATA_W  = 16;
	localparam int CNT_W   = 16;
	localparam int FIFO_DP = 4;

	// address generation modes (3-bit field, codes 5..7 act as fixed)
	localparam logic [2:0] AM_FIXED    = 3'h0;
	localparam logic [2:0] AM_INC_SRC  = 3'h1;
	localparam logic [2:0] AM_INC_DST  = 3'h2;
	localparam logic [2:0] AM_INC_BOTH = 3'h3;
	localparam logic [2:0] AM_DEC_BOTH = 3'h4;

	// transfer mode bits: bit 0 repeat with reload, bit 1 one element/trigger
	localparam int XM_REPEAT_BIT  = 0;
	localparam int XM_ELEMENT_BIT = 1;

	// data mode bits: bit 1 source is sram, bit 0 destination is sram
	localparam int DM_SRC_RAM_BIT = 1;
	localparam int DM_DST_RAM_BIT = 0;

	// address steps and reset values
	localparam logic [ADDR_W-1:0] STEP_BYTE = 16'h0001;
	localparam logic [ADDR_W-1:0] STEP_WORD = 16'h0002;
	localparam logic [ADDR_W-1:0] ADDR_RST  = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_RST   = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;
	localparam logic [DATA_W-1:0] NULL_DATA = 16'h0000;

	// one element travelling from the read side to the write side
	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [ADDR_W-1:0] dst;
		logic [CH_W-1:0]   ch;
		logic              dst_ram;
		logic              byte_sz;
		logic              last;
		logic              half;
	} fifo_word_t;

	localparam int FW_W = $bits(fifo_word_t);

endpackage

// [hdl/dma_fifo.sv]
// small first-word-fall-through fifo between read and write engines
// assumes a single clock; out_data is taken from registered storage
`timescale 1ns/1ps
`default_nettype none
module dma_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             SYS_CLK,
	input  wire logic             RST_N,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr_ptr;
		logic [PW-1:0]               rd_ptr;
		logic [PW:0]                 count;
	} fifo_st_t;

	fifo_st_t s_reg;
	fifo_st_t s_next;
	logic     push;
	logic     pop;

	// honest flags straight from the occupancy count
	assign in_ready  = (s_reg.count != (PW+1)'(DEPTH));
	assign out_valid = (s_reg.count != '0);
	assign out_data  = s_reg.mem[s_reg.rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer wrap and occupancy update
	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wr_ptr] = in_data;
			s_next.wr_ptr = (s_reg.wr_ptr == PW'(DEPTH-1)) ? '0 :
				s_reg.wr_ptr + PW'(1);
		end
		if (pop) begin
			s_next.rd_ptr = (s_reg.rd_ptr == PW'(DEPTH-1)) ? '0 :
				s_reg.rd_ptr + PW'(1);
		end
		if (push && !pop) begin
			s_next.count = s_reg.count + (PW+1)'(1);
		end else if (pop && !push) begin
			s_next.count = s_reg.count - (PW+1)'(1);
		end
	end

	// state register
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule
`default_nettype wire

// [sim/dma_far_model.sv]
// far side model: dma peripheral bus slaves and the sram behind the engine
// assumes single-cycle read pulses; read data stands while the pulse stands
`timescale 1ns/1ps
`default_nettype none
module dma_far_model
	import dma_pkg::*;
#(
	parameter logic [15:0] PER_KEY = 16'hA5C3,
	parameter logic [15:0] RAM_KEY = 16'h3C5A
) (
	input  wire logic                       SYS_CLK,
	input  wire logic                       RST_N,
	input  wire logic [dma_pkg::ADDR_W-1:0] PBUS_ADDR,
	input  wire logic                       PBUS_RD,
	output logic      [dma_pkg::DATA_W-1:0] PBUS_RDATA,
	input  wire logic [dma_pkg::ADDR_W-1:0] RAM_ADDR,
	input  wire logic                       RAM_RD,
	output logic      [dma_pkg::DATA_W-1:0] RAM_RDATA
);
	logic [dma_pkg::DATA_W-1:0] per_idle;
	logic [dma_pkg::DATA_W-1:0] ram_idle;

	// idle value that a read of the previous cycle's address never returns
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			per_idle <= 16'h0000;
			ram_idle <= 16'h0000;
		end else begin
			per_idle <= ~(PBUS_ADDR ^ PER_KEY);
			ram_idle <= ~(RAM_ADDR ^ RAM_KEY);
		end
	end

	// engine captures in the cycle its read pulse stands
	assign PBUS_RDATA = PBUS_RD ? (PBUS_ADDR ^ PER_KEY) : per_idle;
	assign RAM_RDATA  = RAM_RD ? (RAM_ADDR ^ RAM_KEY) : ram_idle;
endmodule
`default_nettype wire

// [sim/tb_multichannel_dma_controller.sv]
// self-checking bench of the eight-channel dma engine
// assumes the far side model answers reads while the pulse stands
`timescale 1ns/1ps
`default_nettype none
module tb_multichannel_dma_controller;
	import dma_pkg::*;
	localparam logic [15:0] PER_KEY = 16'hA5C3;
	localparam logic [15:0] RAM_KEY = 16'h3C5A;
	logic SYS_CLK = 1'b0, RST_N = 1'b0, CPU_PERIPH_REQ = 1'b0;
	logic [NUM_CH-1:0] CH_ENABLE = '0, CH_TRIGGER = '0;
	logic [NUM_CH-1:0] BYTE_MODE = '0, NULL_WRITE = '0;
	logic [NUM_CH-1:0][15:0] SRC_START = '0, DST_START = '0, COUNT_START = '0;
	logic [NUM_CH-1:0][2:0] ADDR_MODE = '0;
	logic [NUM_CH-1:0][1:0] XFER_MODE = '0, DATA_MODE = '0;
	logic [15:0] LOWER_LIMIT = 16'h0000, UPPER_LIMIT = 16'hFFFF;
	logic [15:0] PBUS_ADDR, PBUS_WDATA, PBUS_RDATA, RAM_ADDR, RAM_WDATA;
	logic [15:0] RAM_RDATA;
	logic CPU_OWNS_PBUS, PBUS_RD, PBUS_WR, PBUS_BYTE, RAM_RD, RAM_WR, RAM_BYTE;
	logic [NUM_CH-1:0] CH_ACTIVE, CH_DONE, CH_HALF, CH_LIMIT_ERR;
	logic [NUM_CH-1:0] done_seen = '0, act_exp = '0, last_m = '0;
	logic req_d = 1'b0;
	logic [32:0] exp_r[$], exp_p[$], got_r[$], got_p[$];
	int half_n[NUM_CH], half_exp[NUM_CH];
	int n_errors = 0, check_count = 0;
	integer seed = 25552;

	dma_ctrl i_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CH_ENABLE(CH_ENABLE),
		.CH_TRIGGER(CH_TRIGGER), .SRC_START(SRC_START), .DST_START(DST_START),
		.COUNT_START(COUNT_START), .ADDR_MODE(ADDR_MODE),
		.XFER_MODE(XFER_MODE), .DATA_MODE(DATA_MODE), .BYTE_MODE(BYTE_MODE),
		.NULL_WRITE(NULL_WRITE), .LOWER_LIMIT(LOWER_LIMIT),
		.UPPER_LIMIT(UPPER_LIMIT), .CPU_PERIPH_REQ(CPU_PERIPH_REQ),
		.CPU_OWNS_PBUS(CPU_OWNS_PBUS), .PBUS_ADDR(PBUS_ADDR),
		.PBUS_WDATA(PBUS_WDATA), .PBUS_RDATA(PBUS_RDATA), .PBUS_RD(PBUS_RD),
		.PBUS_WR(PBUS_WR), .PBUS_BYTE(PBUS_BYTE), .RAM_ADDR(RAM_ADDR),
		.RAM_WDATA(RAM_WDATA), .RAM_RDATA(RAM_RDATA), .RAM_RD(RAM_RD),
		.RAM_WR(RAM_WR), .RAM_BYTE(RAM_BYTE), .CH_ACTIVE(CH_ACTIVE),
		.CH_DONE(CH_DONE), .CH_HALF(CH_HALF), .CH_LIMIT_ERR(CH_LIMIT_ERR));

	dma_far_model #(.PER_KEY(PER_KEY), .RAM_KEY(RAM_KEY)) i_far (
		.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PBUS_ADDR(PBUS_ADDR),
		.PBUS_RD(PBUS_RD), .PBUS_RDATA(PBUS_RDATA), .RAM_ADDR(RAM_ADDR),
		.RAM_RD(RAM_RD), .RAM_RDATA(RAM_RDATA));

	// clock and random cpu demand for the peripheral bus
	always #10 SYS_CLK = ~SYS_CLK;
	always @(posedge SYS_CLK) begin
		#2 CPU_PERIPH_REQ = RST_N && (($random(seed) & 3) == 0);
	end

	task automatic check(input string what, input logic [32:0] seen,
		input logic [32:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// collect writes and pulses, watch bus yielding every cycle
	always @(posedge SYS_CLK) begin
		if (RST_N) begin
			if (RAM_WR) got_r.push_back({RAM_BYTE, RAM_ADDR, RAM_WDATA});
			if (PBUS_WR) got_p.push_back({PBUS_BYTE, PBUS_ADDR, PBUS_WDATA});
			check("cpu_owns", CPU_OWNS_PBUS, req_d);
			check("no_dma_in_cpu_slot", (PBUS_RD | PBUS_WR) & CPU_OWNS_PBUS, 0);
			done_seen = done_seen | CH_DONE;
			for (int i = 0; i < NUM_CH; i++) half_n[i] += CH_HALF[i];
		end
		req_d = CPU_PERIPH_REQ;
	end

	// program a channel and work out the writes it must make
	task automatic setup(input int c, input logic [2:0] am,
		input logic [1:0] xm, input logic [1:0] dm, input logic bm,
		input logic nw, input logic [15:0] s, input logic [15:0] d,
		input logic [15:0] n);
		logic [15:0] st, v;
		st = bm ? STEP_BYTE : STEP_WORD;
		SRC_START[c] = s;
		DST_START[c] = d;
		COUNT_START[c] = n;
		ADDR_MODE[c] = am;
		XFER_MODE[c] = xm;
		DATA_MODE[c] = dm;
		BYTE_MODE[c] = bm;
		NULL_WRITE[c] = nw;
		for (int i = 0; i < n; i++) begin
			v = (s ^ (dm[1] ? RAM_KEY : PER_KEY)) & (bm ? 16'h00FF : 16'hFFFF);
			if (dm[0]) exp_r.push_back({bm, d, v});
			else exp_p.push_back({bm, d, v});
			if (nw && !dm[1]) exp_p.push_back({bm, s, 16'h0000});
			if (am == AM_INC_SRC || am == AM_INC_BOTH) s = s + st;
			else if (am == AM_DEC_BOTH) s = s - st;
			if (am == AM_INC_DST || am == AM_INC_BOTH) d = d + st;
			else if (am == AM_DEC_BOTH) d = d - st;
		end
		half_exp[c] += (n >= 2) ? 1 : 0;
		act_exp[c] = xm[XM_REPEAT_BIT];
	endtask

	task automatic go(input logic [NUM_CH-1:0] m, input logic hold);
		int k;
		done_seen = '0;
		last_m = m;
		CH_ENABLE = CH_ENABLE | m;
		@(posedge SYS_CLK);
		#2 CH_TRIGGER = m;
		@(posedge SYS_CLK);
		#2 if (!hold) CH_TRIGGER = '0;
		k = 0;
		while ((done_seen & m) != m && k < 2000) begin
			@(posedge SYS_CLK);
			#2 k++;
		end
		CH_TRIGGER = '0;
		if (k >= 2000) begin
			check("ch_done", done_seen & m, m);
			end_of_test();
		end else begin
			repeat (8) @(posedge SYS_CLK);
			#2;
		end
	endtask

	// compare collected writes, pulse counts and armed state
	task automatic verify(input string t);
		check("ram_writes", got_r.size(), exp_r.size());
		for (int i = 0; i < exp_r.size() && i < got_r.size(); i++)
			check("ram_addr_data", got_r[i], exp_r[i]);
		check("pbus_writes", got_p.size(), exp_p.size());
		for (int i = 0; i < exp_p.size() && i < got_p.size(); i++)
			check("pbus_addr_data", got_p[i], exp_p[i]);
		for (int i = 0; i < NUM_CH; i++) begin
			check("half_pulses", half_n[i], half_exp[i]);
			half_n[i] = 0;
			half_exp[i] = 0;
		end
		check("active", CH_ACTIVE & last_m, act_exp & last_m);
		exp_r.delete();
		exp_p.delete();
		got_r.delete();
		got_p.delete();
		$display("test %s done", t);
	endtask

	task automatic stop(input logic [NUM_CH-1:0] m);
		CH_ENABLE = CH_ENABLE & ~m;
		@(posedge SYS_CLK);
		#2;
	endtask

	// enable and trigger a channel that is not expected to finish
	task automatic poke(input int c);
		last_m = 8'(1 << c);
		CH_ENABLE[c] = 1'b1;
		@(posedge SYS_CLK);
		#2 CH_TRIGGER[c] = 1'b1;
		@(posedge SYS_CLK);
		#2 CH_TRIGGER[c] = 1'b0;
		repeat (30) @(posedge SYS_CLK);
		#2;
	endtask

	task automatic rnd_run(input int c, input logic [2:0] am);
		logic [1:0] dm;
		logic bm, nw;
		dm = 2'($random(seed));
		bm = 1'($random(seed));
		nw = 1'($random(seed)) & dm[0];
		setup(c, am, 2'b00, dm, bm, nw, 16'h1000 + 16'($random(seed) & 'hFFE),
			16'h4000 + 16'($random(seed) & 'hFFE),
			16'(1 + $unsigned($random(seed)) % 5));
		go(8'(1 << c), 1'b0);
		verify("random");
		stop(8'(1 << c));
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge SYS_CLK);
		#2 RST_N = 1'b1;
		check("reset_out", {CH_ACTIVE, CH_DONE, CH_HALF, CH_LIMIT_ERR}, 0);
		for (int am = 0; am < 8; am++) rnd_run(am, 3'(am));
		setup(0, AM_INC_BOTH, 2'b00, 2'b01, 1'b0, 1'b0, 16'h1100, 16'h5000, 16'h0002);
		setup(1, AM_INC_BOTH, 2'b00, 2'b01, 1'b1, 1'b0, 16'h1200, 16'h6000, 16'h0002);
		go(8'h03, 1'b0);
		verify("arbitration");
		stop(8'h03);
		for (int r = 0; r < 2; r++) begin
			setup(2, AM_INC_SRC, 2'b01, 2'b01, 1'b0, 1'b1, 16'h1300, 16'h7000, 16'h0003);
			go(8'h04, 1'b0);
			verify("repeat");
		end
		stop(8'h04);
		setup(7, AM_INC_DST, 2'b10, 2'b10, 1'b0, 1'b0, 16'h2000, 16'h0300, 16'h0003);
		go(8'h80, 1'b1);
		verify("element");
		stop(8'h80);
		LOWER_LIMIT = 16'h8000;
		UPPER_LIMIT = 16'h8FFF;
		setup(3, AM_INC_BOTH, 2'b00, 2'b01, 1'b0, 1'b0, 16'h1000, 16'h2000, 16'h0002);
		exp_r.delete();
		half_exp[3] = 0;
		poke(3);
		check("limit_err", CH_LIMIT_ERR[3], 1);
		verify("limit");
		stop(8'h08);
		setup(3, AM_INC_BOTH, 2'b00, 2'b01, 1'b0, 1'b0, 16'h1000, 16'h8000, 16'h0002);
		go(8'h08, 1'b0);
		check("limit_clear", CH_LIMIT_ERR[3], 0);
		verify("limit_ok");
		stop(8'h08);
		setup(4, AM_INC_BOTH, 2'b00, 2'b01, 1'b0, 1'b0, 16'h1000,
			16'h8000, 16'h0000);
		poke(4);
		check("zero_count_idle", CH_ACTIVE[4], 0);
		verify("zero_count");
		stop(8'h10);
		LOWER_LIMIT = 16'h0000;
		UPPER_LIMIT = 16'hFFFF;
		for (int r = 0; r < 6; r++) rnd_run(r, 3'($random(seed)));
		end_of_test();
	end
endmodule
`default_nettype wire
